/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
    6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13,
    6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] T4D [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  localparam logic [3:0] T4K [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'hA, 4'h6, 4'h8};
  // twelve control bytes, then one that is not
  localparam logic [7:0] KS [13] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC,
    8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE, 8'h00};
  logic clk;
  logic rst_n;
  logic [7:0] tx_data;
  logic tx_k;
  logic tx_ovr_force;
  logic tx_ovr_disp;
  logic tx_valid;
  logic tx_ready;
  logic hold;
  logic idle_fill;
  logic [9:0] ser_code;
  logic ser_valid;
  logic ser_kerr;
  logic ser_disp;
  logic [10:0] sq [$];
  logic [10:0] mw;
  logic [11:0] me;
  logic mrd;
  logic [31:0] seed = 32'h83ADEBEE;
  logic [31:0] r;
  int fail_count;
  int cmp_count;
  int idle_cnt;
  int cyc;
  int n;

  tbe_link_if tbe_link_if_inst ();
  tbe_driver tbe_driver_inst (.clk, .rst_n, .ce(1'b1), .tx_data, .tx_k, .tx_ovr_force,
    .tx_ovr_disp, .tx_valid, .tx_ready, .hold, .idle_fill, .ser_code, .ser_valid,
    .ser_kerr, .ser_disp, .link(tbe_link_if_inst));
  tbe_encoder tbe_encoder_inst (.clk, .rst_n, .ce(1'b1), .link(tbe_link_if_inst));
  tbe_link_properties tbe_link_properties_inst (.clk, .rst_n,
    .data(tbe_link_if_inst.data), .kin(tbe_link_if_inst.kin),
    .enable(tbe_link_if_inst.enable), .idle_ins(tbe_link_if_inst.idle_ins),
    .rd_in(tbe_link_if_inst.rd_in), .rd_force(tbe_link_if_inst.rd_force),
    .code(tbe_link_if_inst.code), .code_valid(tbe_link_if_inst.code_valid),
    .kerr(tbe_link_if_inst.kerr), .rd_out(tbe_link_if_inst.rd_out),
    .rd_cascade(tbe_link_if_inst.rd_cascade));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // {control error, disparity after, code with bit 0 sent first}
  function automatic logic [11:0] enc_ref(input logic [7:0] d, input logic k, input logic rd0);
    logic [5:0] s6;
    logic [3:0] s4;
    logic [9:0] w;
    logic [9:0] c;
    logic kv;
    logic rd1;
    kv = d[4:0] == 5'h1C || d[7:5] == 3'h7 && d[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E};
    s6 = (k && d[4:0] == 5'h1C) ? 6'h0F : T6[d[4:0]];
    if (k && kv) begin
      w = rd0 ? ~{s6, T4K[d[7:5]]} : {s6, T4K[d[7:5]]};
    end else begin
      if (rd0 && ($countones(s6) != 3 || d[4:0] == 5'h07)) begin
        s6 = ~s6;
      end
      rd1 = ($countones(s6) == 3) ? rd0 : !rd0;
      s4 = T4D[d[7:5]];
      // alternate x.7 avoids a run of five across the sub-blocks
      if (d[7:5] == 3'h7 && (rd1 ? d[4:0] inside {5'h0B, 5'h0D, 5'h0E}
          : d[4:0] inside {5'h11, 5'h12, 5'h14})) begin
        s4 = 4'h7;
      end
      if (rd1 && ($countones(s4) != 2 || d[7:5] == 3'h3)) begin
        s4 = ~s4;
      end
      w = {s6, s4};
    end
    rd1 = ($countones(w[9:4]) == 3) ? rd0 : !rd0;
    c = {<<{w}};
    return {k && !kv, ($countones(w[3:0]) == 2) ? rd1 : !rd1, c};
  endfunction : enc_ref

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // word is {override disparity, override, control, byte}
  task automatic send(input logic [10:0] w);
    {tx_ovr_disp, tx_ovr_force, tx_k, tx_data} = w;
    tx_valid = 1'b1;
    do @(posedge clk); while (tx_ready !== 1'b1);
    sq.push_back(w);
    #1;
  endtask : send

  task automatic drain();
    tx_valid = 1'b0;
    hold = 1'b0;
    n = 0;
    while (sq.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    #1;
    check("drained", sq.size(), 0);
  endtask : drain

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // an empty queue means the word must be an idle comma
  always @(posedge clk) begin
    cyc++;
    if (rst_n && ser_valid === 1'b1) begin
      idle_cnt += (sq.size() == 0) ? 1 : 0;
      mw = (sq.size() == 0) ? 11'h1BC : sq.pop_front();
      me = enc_ref(mw[7:0], mw[8], mw[9] ? mw[10] : mrd);
      check("code", 32'(ser_code), 32'(me[9:0]));
      check("kerr", 32'(ser_kerr), 32'(me[11]));
      check("disp", 32'(ser_disp), 32'(me[10]));
      mrd = me[10];
    end
    if (cyc == 8000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    {rst_n, tx_data, tx_k, tx_ovr_force, tx_ovr_disp, tx_valid, hold, idle_fill} = '0;
    mrd = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 26; i++) send({3'h1, KS[i % 13]});
    drain();
    for (int i = 0; i < 400; i++) begin
      r = rnd();
      if (r[21:20] == 2'h0) begin
        tx_valid = 1'b0;
        hold = r[22];
        @(posedge clk);
        #1;
      end else begin
        hold = 1'b0;
        send({r[10], r[13:11] == 3'h0, r[16:14] == 3'h0,
          (r[16:14] == 3'h0) ? KS[r[27:24] % 13] : r[7:0]});
      end
    end
    drain();
    // stalled drain: the ninth push must be refused
    hold = 1'b1;
    n = 0;
    while (n < 20) begin
      r = rnd();
      {tx_ovr_force, tx_k, tx_data, tx_valid} = {2'h0, r[7:0], 1'b1};
      @(posedge clk);
      if (tx_ready !== 1'b1) break;
      sq.push_back({3'h0, r[7:0]});
      n++;
      #1;
    end
    #1 tx_valid = 1'b0;
    check("fill", n, tbe_pkg::FIFO_DEPTH);
    repeat (6) @(posedge clk);
    #1 drain();
    idle_cnt = 0;
    idle_fill = 1'b1;
    repeat (20) @(posedge clk);
    #1 idle_fill = 1'b0;
    repeat (8) @(posedge clk);
    #1 check("idle", idle_cnt, 20);
    // reset in mid-stream clears at once, without a clock
    for (int i = 0; i < 6; i++) send({3'h0, 8'hF1});
    tx_valid = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b0;
    #1 check("reset", {ser_valid, ser_kerr, ser_disp}, 0);
    sq.delete();
    mrd = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 13; i++) send({3'h1, KS[i]});
    drain();
    report_and_stop();
  end
endmodule : tb_top

/* dv/tbe_link_properties.sv */
`timescale 1ns/10ps
module tbe_link_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // encoder inputs
  input wire logic [7:0] data,
  input wire logic kin,
  input wire logic enable,
  input wire logic idle_ins,
  input wire logic rd_in,
  input wire logic rd_force,
  // encoder outputs
  input wire logic [9:0] code,
  input wire logic code_valid,
  input wire logic kerr,
  input wire logic rd_out,
  input wire logic rd_cascade
);
  logic k_ok;
  logic bad_k;
  logic [3:0] ones;
  logic rd_used_r;
  logic rd_used_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  assign k_ok = data[4:0] == 5'h1C
    || data[7:5] == 3'h7 && data[4:0] inside {5'h17, 5'h1B, 5'h1D, 5'h1E};
  assign bad_k = enable && kin && !k_ok;
  assign ones = 4'($countones(code));

  // disparity the last stage used; the word shows one edge later
  always_comb begin
    rd_used_nxt = rd_force ? rd_in : rd_out;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_used_r <= 1'b0;
    end else begin
      rd_used_r <= rd_used_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  word_latency_a: assert property ((enable || idle_ins) |-> ##3 code_valid)
    else $error("word late");
  no_word_a: assert property (!(enable || idle_ins) |-> ##3 !code_valid)
    else $error("valid without request");
  kerr_match_a: assert property (kerr == $past(bad_k, 3))
    else $error("control error flag wrong");
  idle_comma_a: assert property (
    idle_ins && !enable |-> ##3 code inside {10'h17C, 10'h283})
    else $error("idle word not comma");
  word_balance_a: assert property (code_valid |-> ones inside {4'h4, 4'h5, 4'h6})
    else $error("word unbalanced");
  rd_pick_a: assert property (
    code_valid && ones != 4'h5 |-> (ones > 4'h5) == !rd_used_r)
    else $error("wrong polarity chosen");
  rd_after_a: assert property (
    code_valid |-> rd_out == (ones == 4'h5 ? rd_used_r : ones > 4'h5))
    else $error("disparity out wrong");
  cascade_out_a: assert property (code_valid |-> rd_out == $past(rd_cascade))
    else $error("cascade disparity wrong");
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n && !$past(rst_n) |-> !code_valid && !kerr && !rd_out)
    else $error("reset did not clear");

  cover property (code_valid && kerr);
  cover property (code_valid && code == 10'h17C);
  cover property (rd_force && rd_in ##1 code_valid);
endmodule : tbe_link_properties

/* verilog/tbe_driver.sv */
`timescale 1ns/10ps
module tbe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    in_ready = (cnt_r != DEPTH[AW:0]);
    out_valid = (cnt_r != '0);
    out_data = mem[rp_r];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? ((wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; empty flag guards stale words
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end

endmodule : tbe_fifo

////////////////////////////////////////////////////////////////////////////////

module tbe_driver (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // byte source
  input wire logic [7:0] tx_data,
  input wire logic tx_k,
  input wire logic tx_ovr_force,
  input wire logic tx_ovr_disp,
  input wire logic tx_valid,
  output logic tx_ready,
  // control
  input wire logic hold,
  input wire logic idle_fill,
  // serializer side
  output logic [9:0] ser_code,
  output logic ser_valid,
  output logic ser_kerr,
  output logic ser_disp,
  // link
  tbe_link_if.drv link
);

  logic [tbe_pkg::FIFO_W-1:0] q_data;
  logic q_valid, q_ready;

  tbe_fifo #(.WIDTH(tbe_pkg::FIFO_W), .DEPTH(tbe_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data({tx_ovr_disp, tx_ovr_force, tx_k, tx_data}),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link drive

  logic [7:0] data_r, data_nxt;
  logic k_r, k_nxt;
  logic en_r, en_nxt;
  logic idle_r, idle_nxt;
  logic [2:0] f_r, f_nxt;
  logic [2:0] d_r, d_nxt;

  always_comb begin
    q_ready = !hold;
    en_nxt = q_valid && !hold;
    data_nxt = en_nxt ? q_data[7:0] : data_r;
    k_nxt = en_nxt && q_data[8];
    idle_nxt = idle_fill;
    // override trails its byte by two registers to meet the final stage
    // first stage sits beside the byte register, two more follow it
    f_nxt = {f_r[1:0], en_nxt && q_data[9]};
    d_nxt = {d_r[1:0], q_data[10]};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= 8'h00;
      k_r <= 1'b0;
      en_r <= 1'b0;
      idle_r <= 1'b0;
      f_r <= 3'h0;
      d_r <= 3'h0;
    end else if (ce) begin
      data_r <= data_nxt;
      k_r <= k_nxt;
      en_r <= en_nxt;
      idle_r <= idle_nxt;
      f_r <= f_nxt;
      d_r <= d_nxt;
    end
  end

  assign link.data = data_r;
  assign link.kin = k_r;
  assign link.enable = en_r;
  assign link.idle_ins = idle_r;
  assign link.rd_force = f_r[2];
  assign link.rd_in = d_r[2];
  assign ser_code = link.code;
  assign ser_valid = link.code_valid;
  assign ser_kerr = link.kerr;
  assign ser_disp = link.rd_out;

endmodule : tbe_driver

/* verilog/tbe_encoder.sv */
`timescale 1ns/10ps
module tbe_encoder (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // link
  tbe_link_if.enc link
);

  ////////////////////////////////////////////////////////////////////////////
  // sub-block lookups for negative running disparity

  function automatic logic [5:0] sub6_lookup(input logic [4:0] low);
    logic [5:0] c;
    c = 6'h00;
    unique case (low)
      5'h00: c = 6'h27;
      5'h01: c = 6'h1D;
      5'h02: c = 6'h2D;
      5'h03: c = 6'h31;
      5'h04: c = 6'h35;
      5'h05: c = 6'h29;
      5'h06: c = 6'h19;
      5'h07: c = 6'h38;
      5'h08: c = 6'h39;
      5'h09: c = 6'h25;
      5'h0A: c = 6'h15;
      5'h0B: c = 6'h34;
      5'h0C: c = 6'h0D;
      5'h0D: c = 6'h2C;
      5'h0E: c = 6'h1C;
      5'h0F: c = 6'h17;
      5'h10: c = 6'h1B;
      5'h11: c = 6'h23;
      5'h12: c = 6'h13;
      5'h13: c = 6'h32;
      5'h14: c = 6'h0B;
      5'h15: c = 6'h2A;
      5'h16: c = 6'h1A;
      5'h17: c = 6'h3A;
      5'h18: c = 6'h33;
      5'h19: c = 6'h26;
      5'h1A: c = 6'h16;
      5'h1B: c = 6'h36;
      5'h1C: c = 6'h0E;
      5'h1D: c = 6'h2E;
      5'h1E: c = 6'h1E;
      5'h1F: c = 6'h2B;
    endcase
    return c;
  endfunction : sub6_lookup

  function automatic logic [3:0] sub4_lookup(input logic [2:0] high);
    logic [3:0] c;
    c = 4'h0;
    unique case (high)
      3'h0: c = 4'hB;
      3'h1: c = 4'h9;
      3'h2: c = 4'h5;
      3'h3: c = 4'hC;
      3'h4: c = 4'hD;
      3'h5: c = 4'hA;
      3'h6: c = 4'h6;
      3'h7: c = 4'hE;
    endcase
    return c;
  endfunction : sub4_lookup

  ////////////////////////////////////////////////////////////////////////////
  // stage 1: input capture

  logic [7:0] byte1_r, byte1_nxt;
  logic k1_r, k1_nxt;
  logic vld1_r, vld1_nxt;

  always_comb begin
    byte1_nxt = byte1_r;
    k1_nxt = 1'b0;
    vld1_nxt = 1'b0;
    if (link.enable) begin
      byte1_nxt = link.data;
      k1_nxt = link.kin;
      vld1_nxt = 1'b1;
    end else if (link.idle_ins) begin
      byte1_nxt = tbe_pkg::IDLE_BYTE;
      k1_nxt = 1'b1;
      vld1_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte1_r <= 8'h00;
      k1_r <= 1'b0;
      vld1_r <= 1'b0;
    end else if (ce) begin
      byte1_r <= byte1_nxt;
      k1_r <= k1_nxt;
      vld1_r <= vld1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage 2: table lookup and control check

  logic [4:0] low1;
  logic [2:0] high1;
  logic kok1;
  logic [5:0] c6_r, c6_nxt;
  logic [3:0] c4_r, c4_nxt;
  logic d7_r, d7_nxt;
  logic x3_r, x3_nxt;
  logic k28_r, k28_nxt;
  logic kalt_r, kalt_nxt;
  logic altn_r, altn_nxt;
  logic altp_r, altp_nxt;
  logic kerr2_r, kerr2_nxt;
  logic vld2_r, vld2_nxt;

  always_comb begin
    low1 = byte1_r[tbe_pkg::LOW_LSB +: tbe_pkg::LOW_W];
    high1 = byte1_r[tbe_pkg::HIGH_LSB +: tbe_pkg::HIGH_W];
    kok1 = (low1 == tbe_pkg::K28_LOW) ||
           (high1 == tbe_pkg::K7_HIGH && (low1 == tbe_pkg::K23_LOW ||
            low1 == tbe_pkg::K27_LOW || low1 == tbe_pkg::K29_LOW ||
            low1 == tbe_pkg::K30_LOW));
    c6_nxt = (k1_r && low1 == tbe_pkg::K28_LOW) ? tbe_pkg::K28_SUB6 : sub6_lookup(low1);
    c4_nxt = sub4_lookup(high1);
    d7_nxt = (c6_nxt == tbe_pkg::D7_SUB6);
    x3_nxt = (high1 == tbe_pkg::HIGH_3);
    k28_nxt = k1_r && kok1 && low1 == tbe_pkg::K28_LOW;
    // every valid control ending in 7 uses the alternate sub-block
    kalt_nxt = k1_r && kok1 && high1 == tbe_pkg::K7_HIGH;
    // alternate x.7 avoids a run of five around the sub-block seam
    // only the x.7 tail has an alternate; other tails keep their table code
    altn_nxt = (high1 == tbe_pkg::K7_HIGH) &&
               (low1 == 5'h11 || low1 == 5'h12 || low1 == 5'h14);
    altp_nxt = (high1 == tbe_pkg::K7_HIGH) &&
               (low1 == 5'h0B || low1 == 5'h0D || low1 == 5'h0E);
    kerr2_nxt = vld1_r && k1_r && !kok1;
    vld2_nxt = vld1_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c6_r <= 6'h00;
      c4_r <= 4'h0;
      d7_r <= 1'b0;
      x3_r <= 1'b0;
      k28_r <= 1'b0;
      kalt_r <= 1'b0;
      altn_r <= 1'b0;
      altp_r <= 1'b0;
      kerr2_r <= 1'b0;
      vld2_r <= 1'b0;
    end else if (ce) begin
      c6_r <= c6_nxt;
      c4_r <= c4_nxt;
      d7_r <= d7_nxt;
      x3_r <= x3_nxt;
      k28_r <= k28_nxt;
      kalt_r <= kalt_nxt;
      altn_r <= altn_nxt;
      altp_r <= altp_nxt;
      kerr2_r <= kerr2_nxt;
      vld2_r <= vld2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stage 3: disparity choice and output

  logic rd_r, rd_nxt;
  logic rd_cur, rd4, rd_after;
  logic unbal6, unbal4, flip6, flip4;
  logic [5:0] s6;
  logic [3:0] b4, s4;
  logic [9:0] raw;
  logic [9:0] word;
  logic [9:0] code_r, code_nxt;
  logic vld3_r, vld3_nxt;
  logic kerr3_r, kerr3_nxt;

  always_comb begin
    // override is not pipelined so a cascaded partner can feed it
    rd_cur = link.rd_force ? link.rd_in : rd_r;
    unbal6 = ($countones(c6_r) != tbe_pkg::SUB6_BAL_ONES);
    flip6 = rd_cur && (unbal6 || d7_r);
    s6 = flip6 ? ~c6_r : c6_r;
    rd4 = rd_cur ^ unbal6;
    b4 = (kalt_r || (rd4 ? altp_r : altn_r)) ? tbe_pkg::ALT7_SUB4 : c4_r;
    unbal4 = ($countones(b4) != tbe_pkg::SUB4_BAL_ONES);
    // control 28 also flips balanced tails to keep the comma unique
    flip4 = rd4 ? (unbal4 || x3_r) : (k28_r && !unbal4 && !x3_r);
    s4 = flip4 ? ~b4 : b4;
    rd_after = rd4 ^ unbal4;
    raw = {s6, s4};
    for (int i = 0; i < tbe_pkg::CODE_W; i++) begin
      word[i] = raw[tbe_pkg::CODE_W - 1 - i];
    end
    code_nxt = code_r;
    rd_nxt = rd_r;
    if (vld2_r) begin
      code_nxt = word;
      rd_nxt = rd_after;
    end
    vld3_nxt = vld2_r;
    kerr3_nxt = kerr2_r;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_r <= 10'h000;
      rd_r <= tbe_pkg::RD_RESET;
      vld3_r <= 1'b0;
      kerr3_r <= 1'b0;
    end else if (ce) begin
      code_r <= code_nxt;
      rd_r <= rd_nxt;
      vld3_r <= vld3_nxt;
      kerr3_r <= kerr3_nxt;
    end
  end

  assign link.code = code_r;
  assign link.code_valid = vld3_r;
  assign link.kerr = kerr3_r;
  assign link.rd_out = rd_r;
  // disparity after the word now in the final stage, for the partner
  assign link.rd_cascade = vld2_r ? rd_after : rd_cur;

endmodule : tbe_encoder

/* verilog/tbe_link_if.sv */
`timescale 1ns/10ps
interface tbe_link_if;
  logic [7:0] data;
  logic kin;
  logic enable;
  logic idle_ins;
  logic rd_in;
  logic rd_force;
  logic [9:0] code;
  logic code_valid;
  logic kerr;
  logic rd_out;
  logic rd_cascade;

  modport enc (
    input data, kin, enable, idle_ins, rd_in, rd_force,
    output code, code_valid, kerr, rd_out, rd_cascade
  );

  modport drv (
    output data, kin, enable, idle_ins, rd_in, rd_force,
    input code, code_valid, kerr, rd_out, rd_cascade
  );
endinterface : tbe_link_if

/* verilog/tbe_pkg.sv */
package tbe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and depths
  localparam int BYTE_W = 8;
  localparam int CODE_W = 10;
  localparam int LOW_W = 5;
  localparam int HIGH_W = 3;
  localparam int SUB6_W = 6;
  localparam int SUB4_W = 4;
  localparam int FIFO_DEPTH = 8;
  // byte, control flag, override flag, override disparity
  localparam int FIFO_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // byte fields and control characters
  localparam int LOW_LSB = 0;
  localparam int HIGH_LSB = 5;
  localparam logic [7:0] IDLE_BYTE = 8'hBC;
  localparam logic [4:0] K28_LOW = 5'h1C;
  localparam logic [4:0] K23_LOW = 5'h17;
  localparam logic [4:0] K27_LOW = 5'h1B;
  localparam logic [4:0] K29_LOW = 5'h1D;
  localparam logic [4:0] K30_LOW = 5'h1E;
  localparam logic [2:0] K7_HIGH = 3'h7;
  localparam logic [2:0] HIGH_3 = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // sub-block codes, first transmitted bit in the msb
  localparam logic [5:0] K28_SUB6 = 6'h0F;
  localparam logic [5:0] D7_SUB6 = 6'h38;
  localparam logic [3:0] ALT7_SUB4 = 4'h7;
  localparam int SUB6_BAL_ONES = 3;
  localparam int SUB4_BAL_ONES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // running disparity: 0 negative, 1 positive
  localparam logic RD_NEG = 1'b0;
  localparam logic RD_RESET = RD_NEG;
  localparam int PIPE_STAGES = 3;
  localparam int OVR_DELAY = 2;

endpackage : tbe_pkg
